//--- rtl/dpl_pkg.sv
// Shared constants and types of the process loop regulator
package dpl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_NS  = 10_000_000;  // One setting step, 0.01 s
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_VSET   = 8'h04;
  localparam logic [7:0] ADDR_SSET   = 8'h08;
  localparam logic [7:0] ADDR_GAIN   = 8'h0c;
  localparam logic [7:0] ADDR_TINT   = 8'h10;
  localparam logic [7:0] ADDR_TDER   = 8'h14;
  localparam logic [7:0] ADDR_TPER   = 8'h18;
  localparam logic [7:0] ADDR_BAND   = 8'h1c;
  localparam logic [7:0] ADDR_FFLIM  = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_FREQ   = 8'h28;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FB_LSB   = 4;
  localparam int CTRL_REF_LSB  = 8;
  localparam int CTRL_INTH_BIT = 12;
  localparam int CTRL_ACT_BIT  = 13;
  localparam int CTRL_FF_BIT   = 14;

  // ****************************************
  // Reset values and ranges
  // ****************************************
  localparam logic [15:0] VSET_RST  = 16'h0000;
  localparam logic [15:0] SSET_RST  = 16'h0000;
  localparam logic [15:0] GAIN_RST  = 16'h05dc;  // 1.500
  localparam logic [15:0] TINT_RST  = 16'h0000;
  localparam logic [15:0] TDER_RST  = 16'h0000;
  localparam logic [15:0] TPER_RST  = 16'h0032;  // 0.50 s
  localparam logic [15:0] BAND_RST  = 16'h0014;  // 2.0 %
  localparam logic [15:0] FFLIM_RST = 16'h0064;  // 1.00 Hz
  localparam logic [15:0] VSET_MAX  = 16'h03e8;  // 10.00 V
  localparam logic [15:0] SSET_MAX  = 16'h5dc0;  // 24000 rpm
  localparam logic [15:0] GAIN_MAX  = 16'h2710;  // 10.000
  localparam logic [15:0] TIME_MAX  = 16'h2710;  // 100.00 s
  localparam logic [15:0] TPER_MIN  = 16'h0001;  // 0.01 s
  localparam logic [15:0] BAND_MAX  = 16'h00c8;  // 20.0 %
  localparam logic [15:0] FFLIM_MAX = 16'h01f4;  // 5.00 Hz

  // ****************************************
  // Scaling
  // ****************************************
  localparam logic [15:0] VOLT_FULL     = 16'h03e8;  // 10.00 V in 0.01 V
  localparam logic [15:0] RPM_PER_CV    = 16'h0018;  // 24000 rpm over 1000 steps
  localparam logic [15:0] GAIN_SCALE    = 16'h03e8;  // Gain step 0.001
  localparam logic [15:0] BAND_SCALE    = 16'h03e8;  // Band step 0.1 %

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_AI_AF,
    MODE_VSET_AF,
    MODE_AI_ENC,
    MODE_SSET_ENC
  } dpl_mode_t;

endpackage : dpl_pkg

//--- rtl/dpl_sample_timer.sv
// Sampling period pulse generator counted in 0.01 s steps
`timescale 1ns/1ns
module dpl_sample_timer #(
  parameter int unsigned TICK_CYCLES = dpl_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output logic             sample_tick
);

  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [15:0] step_q;
  logic [15:0] step_d;
  logic        tick_d;

  always_comb begin
    pre_d  = pre_q;
    step_d = step_q;
    tick_d = 1'b0;
    if (!run) begin
      pre_d  = '0;
      step_d = '0;
    end else if (pre_q == 32'(TICK_CYCLES - 1)) begin
      pre_d = '0;
      if (step_q + 16'h0001 >= period) begin
        step_d = '0;
        tick_d = 1'b1;
      end else begin
        step_d = step_q + 16'h0001;
      end
    end else begin
      pre_d = pre_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q       <= '0;
      step_q      <= '0;
      sample_tick <= 1'b0;
    end else begin
      pre_q       <= pre_d;
      step_q      <= step_d;
      sample_tick <= tick_d;
    end
  end

endmodule : dpl_sample_timer

//--- rtl/dpl_pid_core.sv
// One positional regulator step: integral update and gain-scaled sum
`timescale 1ns/1ns
module dpl_pid_core (
  input  wire logic signed [31:0] err,
  input  wire logic signed [31:0] err_prev,
  input  wire logic signed [47:0] integ_q,
  input  wire logic               integ_freeze,
  input  wire logic        [15:0] gain,
  input  wire logic        [15:0] t_int,
  input  wire logic        [15:0] t_der,
  input  wire logic        [15:0] t_per,
  input  wire logic               inverse,
  output logic signed      [47:0] integ_d,
  output logic signed      [47:0] pid_out
);

  logic signed [47:0] i_term;
  logic signed [47:0] d_term;
  logic signed [47:0] sum;
  logic signed [47:0] scaled;

  always_comb begin
    integ_d = integ_q;
    i_term  = '0;
    d_term  = '0;
    if (t_int != 16'h0000) begin
      if (!integ_freeze) begin
        integ_d = integ_q + 48'(err) * $signed({32'h0, t_per});
      end
      i_term = integ_d / $signed({32'h0, t_int});
    end
    if (t_der != 16'h0000) begin
      d_term = (48'(err) - 48'(err_prev)) * $signed({32'h0, t_der})
               / $signed({32'h0, t_per});
    end
    sum    = 48'(err) + i_term + d_term;
    scaled = sum * $signed({32'h0, gain}) / $signed({32'h0, dpl_pkg::GAIN_SCALE});
    pid_out = inverse ? -scaled : scaled;
  end

endmodule : dpl_pid_core

//--- rtl/dpl_loop_top.sv
// Process loop regulator with its AHB-Lite settings port
// Summary of operation
// - PID of reference minus feedback moves the frequency to cancel the deviation.
// - Mode 0 off; 1 analog/analog; 2 voltage set/analog; 3 analog/encoder; 4 speed/encoder.
// - Voltage setpoint 0.00-10.00 V, 0.01 V steps, default 0, used only in mode 2.
// - Speed setpoint 0-24000 rpm, 1 rpm steps, default 0, used only in mode 4.
// - Modes 1,2 feedback: current, voltage one, two, three; odd codes invert.
// - Modes 1,3 reference: 0 current, 1-3 voltage inputs one to three.
// - Gain 0-10.000 default 1.500; sampling period 0.01-100.00 s default 0.50 s.
// - Integral time 0-100.00 s, default 0; zero removes the integral term.
// - Derivative time 0-100.00 s, default 0; zero removes the derivative term.
// - Deviation within 0-20.0 % of reference (default 2.0 %) holds the output.
// - Handling mode 0 freezes the integral at a frequency limit while the deviation pushes further into it.
// - Handling mode 1 keeps integrating even at a frequency limit.
// - Output action 0 direct, 1 inverse; default direct.
// - Without feedforward, active loop output is the frequency command; mode 0 ordinary.
// - With feedforward, command is main setting plus loop output; mode 0 ordinary.
// - Feedforward limit 0.00-5.00 Hz, default 1.00 Hz, bounds the added trim.
`timescale 1ns/1ns
module dpl_loop_top #(
  parameter int unsigned TICK_CYCLES = dpl_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] current_input,
  input  wire logic [15:0] voltage_input_one,
  input  wire logic [15:0] voltage_input_two,
  input  wire logic [15:0] voltage_input_three,
  input  wire logic [15:0] encoder_speed,
  input  wire logic [15:0] main_frequency_setting,
  input  wire logic [15:0] ordinary_frequency_setting,
  input  wire logic [15:0] upper_frequency_limit,
  input  wire logic [15:0] lower_frequency_limit,
  output logic [15:0]      frequency_command,
  output logic             regulator_active
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lim_u(input logic [31:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < {16'h0, lo}) return lo;
    if (v > {16'h0, hi}) return hi;
    return v[15:0];
  endfunction : lim_u

  function automatic logic signed [47:0] lim_s(input logic signed [47:0] v,
                                               input logic signed [47:0] lo,
                                               input logic signed [47:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : lim_s

  function automatic logic [15:0] pick_input(input logic [1:0] code,
                                             input logic [15:0] a, input logic [15:0] b,
                                             input logic [15:0] c, input logic [15:0] d);
    case (code)
      2'h0:    return a;
      2'h1:    return b;
      2'h2:    return c;
      default: return d;
    endcase
  endfunction : pick_input

  // ****************************************
  // Bus slave
  // ****************************************
  logic        dp_valid_q, dp_valid_d;
  logic        dp_write_q, dp_write_d;
  logic [7:0]  dp_addr_q,  dp_addr_d;
  logic        rd_done_q,  rd_done_d;
  logic [31:0] hrdata_d;
  logic        take_addr;
  logic        wr_en;
  logic        dp_read_wait;

  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] vset_q, vset_d;
  logic [15:0] sset_q, sset_d;
  logic [15:0] gain_q, gain_d;
  logic [15:0] tint_q, tint_d;
  logic [15:0] tder_q, tder_d;
  logic [15:0] tper_q, tper_d;
  logic [15:0] band_q, band_d;
  logic [15:0] fflim_q, fflim_d;

  logic [15:0] freq_q, freq_d;
  logic        in_band_q, in_band_d;
  logic        sat_q, sat_d;

  assign take_addr    = hsel && htrans[1] && hready;
  assign dp_read_wait = dp_valid_q && !dp_write_q && !rd_done_q;
  assign wr_en        = dp_valid_q && dp_write_q && hready;
  assign hreadyout    = !dp_read_wait;
  assign hresp        = 1'b0;

  always_comb begin
    dp_valid_d = dp_valid_q;
    dp_write_d = dp_write_q;
    dp_addr_d  = dp_addr_q;
    rd_done_d  = 1'b0;
    hrdata_d   = hrdata;
    if (hready) begin
      dp_valid_d = take_addr;
      dp_write_d = hwrite;
      dp_addr_d  = haddr[7:0];
    end else begin
      rd_done_d = dp_read_wait;
    end
    // Read data is sampled in the wait cycle so a write just before is seen
    if (dp_read_wait) begin
      if (dp_addr_q == dpl_pkg::ADDR_CTRL) begin
        hrdata_d = {16'h0, ctrl_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_VSET) begin
        hrdata_d = {16'h0, vset_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_SSET) begin
        hrdata_d = {16'h0, sset_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_GAIN) begin
        hrdata_d = {16'h0, gain_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_TINT) begin
        hrdata_d = {16'h0, tint_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_TDER) begin
        hrdata_d = {16'h0, tder_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_TPER) begin
        hrdata_d = {16'h0, tper_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_BAND) begin
        hrdata_d = {16'h0, band_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_FFLIM) begin
        hrdata_d = {16'h0, fflim_q};
      end else if (dp_addr_q == dpl_pkg::ADDR_STATUS) begin
        hrdata_d = {29'h0, sat_q, in_band_q, regulator_active};
      end else if (dp_addr_q == dpl_pkg::ADDR_FREQ) begin
        hrdata_d = {16'h0, freq_q};
      end else begin
        hrdata_d = 32'h0000_0000;
      end
    end
  end

  // Settings are clamped into their printed ranges on write
  always_comb begin
    ctrl_d  = ctrl_q;
    vset_d  = vset_q;
    sset_d  = sset_q;
    gain_d  = gain_q;
    tint_d  = tint_q;
    tder_d  = tder_q;
    tper_d  = tper_q;
    band_d  = band_q;
    fflim_d = fflim_q;
    if (wr_en) begin
      if (dp_addr_q == dpl_pkg::ADDR_CTRL) begin
        ctrl_d = hwdata[15:0] & 16'h7377;
      end else if (dp_addr_q == dpl_pkg::ADDR_VSET) begin
        vset_d = lim_u(hwdata, 16'h0000, dpl_pkg::VSET_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_SSET) begin
        sset_d = lim_u(hwdata, 16'h0000, dpl_pkg::SSET_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_GAIN) begin
        gain_d = lim_u(hwdata, 16'h0000, dpl_pkg::GAIN_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_TINT) begin
        tint_d = lim_u(hwdata, 16'h0000, dpl_pkg::TIME_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_TDER) begin
        tder_d = lim_u(hwdata, 16'h0000, dpl_pkg::TIME_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_TPER) begin
        tper_d = lim_u(hwdata, dpl_pkg::TPER_MIN, dpl_pkg::TIME_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_BAND) begin
        band_d = lim_u(hwdata, 16'h0000, dpl_pkg::BAND_MAX);
      end else if (dp_addr_q == dpl_pkg::ADDR_FFLIM) begin
        fflim_d = lim_u(hwdata, 16'h0000, dpl_pkg::FFLIM_MAX);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
      rd_done_q  <= 1'b0;
      hrdata     <= 32'h0000_0000;
      ctrl_q     <= 16'h0000;
      vset_q     <= dpl_pkg::VSET_RST;
      sset_q     <= dpl_pkg::SSET_RST;
      gain_q     <= dpl_pkg::GAIN_RST;
      tint_q     <= dpl_pkg::TINT_RST;
      tder_q     <= dpl_pkg::TDER_RST;
      tper_q     <= dpl_pkg::TPER_RST;
      band_q     <= dpl_pkg::BAND_RST;
      fflim_q    <= dpl_pkg::FFLIM_RST;
    end else begin
      dp_valid_q <= dp_valid_d;
      dp_write_q <= dp_write_d;
      dp_addr_q  <= dp_addr_d;
      rd_done_q  <= rd_done_d;
      hrdata     <= hrdata_d;
      ctrl_q     <= ctrl_d;
      vset_q     <= vset_d;
      sset_q     <= sset_d;
      gain_q     <= gain_d;
      tint_q     <= tint_d;
      tder_q     <= tder_d;
      tper_q     <= tper_d;
      band_q     <= band_d;
      fflim_q    <= fflim_d;
    end
  end

  // ****************************************
  // Reference and feedback selection
  // ****************************************
  dpl_pkg::dpl_mode_t mode;
  logic [2:0]         fb_code;
  logic [1:0]         ref_code;
  logic               ff_en;
  logic               inverse;
  logic [15:0]        ai_ref;
  logic [15:0]        ai_fb;
  logic signed [31:0] ref_val;
  logic signed [31:0] fb_val;
  logic signed [31:0] err;
  logic [31:0]        err_mag;
  logic               in_band;

  assign fb_code  = ctrl_q[dpl_pkg::CTRL_FB_LSB +: 3];
  assign ref_code = ctrl_q[dpl_pkg::CTRL_REF_LSB +: 2];
  assign ff_en    = ctrl_q[dpl_pkg::CTRL_FF_BIT];
  assign inverse  = ctrl_q[dpl_pkg::CTRL_ACT_BIT];
  assign ai_ref   = pick_input(ref_code, current_input, voltage_input_one,
                               voltage_input_two, voltage_input_three);
  assign ai_fb    = pick_input(fb_code[2:1], current_input, voltage_input_one,
                               voltage_input_two, voltage_input_three);

  always_comb begin
    case (ctrl_q[dpl_pkg::CTRL_MODE_LSB +: 3])
      3'h1:    mode = dpl_pkg::MODE_AI_AF;
      3'h2:    mode = dpl_pkg::MODE_VSET_AF;
      3'h3:    mode = dpl_pkg::MODE_AI_ENC;
      3'h4:    mode = dpl_pkg::MODE_SSET_ENC;
      default: mode = dpl_pkg::MODE_OFF;
    endcase
    ref_val = '0;
    fb_val  = fb_code[0] ? $signed({16'h0, dpl_pkg::VOLT_FULL}) - $signed({16'h0, ai_fb})
                         : $signed({16'h0, ai_fb});
    case (mode)
      dpl_pkg::MODE_AI_AF: begin
        ref_val = $signed({16'h0, ai_ref});
      end
      dpl_pkg::MODE_VSET_AF: begin
        ref_val = $signed({16'h0, vset_q});
      end
      dpl_pkg::MODE_AI_ENC: begin
        // Encoder modes rely on plain volts-per-hertz control outside
        ref_val = $signed(32'({16'h0, ai_ref} * {16'h0, dpl_pkg::RPM_PER_CV}));
        fb_val  = $signed({16'h0, encoder_speed});
      end
      dpl_pkg::MODE_SSET_ENC: begin
        ref_val = $signed({16'h0, sset_q});
        fb_val  = $signed({16'h0, encoder_speed});
      end
      default: begin
        ref_val = '0;
      end
    endcase
    err     = ref_val - fb_val;
    err_mag = err[31] ? 32'(-err) : 32'(err);
    in_band = err_mag * {16'h0, dpl_pkg::BAND_SCALE}
              <= 32'(ref_val) * {16'h0, band_q};
  end

  // ****************************************
  // Regulator state
  // ****************************************
  logic               sample_tick;
  logic signed [31:0] err_prev_q, err_prev_d;
  logic signed [47:0] integ_q, integ_d, integ_next;
  logic signed [47:0] reg_q, reg_d;
  logic signed [47:0] pid_out;
  logic signed [47:0] trim_sum;
  logic               push_up;
  logic               freeze;

  assign regulator_active  = mode != dpl_pkg::MODE_OFF;
  assign frequency_command = freq_q;
  // Integral only stops when the deviation pushes further into the limit
  assign push_up = inverse ? err[31] : (!err[31] && err != '0);
  assign freeze  = !ctrl_q[dpl_pkg::CTRL_INTH_BIT] && sat_q
                   && (push_up == (freq_q >= upper_frequency_limit));

  dpl_sample_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .run         (regulator_active),
    .period      (tper_q),
    .sample_tick (sample_tick)
  );

  dpl_pid_core u_core (
    .err          (err),
    .err_prev     (err_prev_q),
    .integ_q      (integ_q),
    .integ_freeze (freeze),
    .gain         (gain_q),
    .t_int        (tint_q),
    .t_der        (tder_q),
    .t_per        (tper_q),
    .inverse      (inverse),
    .integ_d      (integ_next),
    .pid_out      (pid_out)
  );

  always_comb begin
    err_prev_d = err_prev_q;
    integ_d    = integ_q;
    reg_d      = reg_q;
    in_band_d  = in_band_q;
    if (!regulator_active) begin
      err_prev_d = '0;
      integ_d    = '0;
      reg_d      = '0;
      in_band_d  = 1'b0;
    end else if (sample_tick) begin
      in_band_d = in_band;
      if (!in_band) begin
        err_prev_d = err;
        integ_d    = integ_next;
        reg_d      = ff_en ? lim_s(pid_out, -$signed({32'h0, fflim_q}),
                                   $signed({32'h0, fflim_q}))
                           : pid_out;
      end
    end
    trim_sum = $signed({32'h0, main_frequency_setting}) + reg_q;
    if (!regulator_active) begin
      freq_d = ordinary_frequency_setting;
    end else if (ff_en) begin
      freq_d = 16'(lim_s(trim_sum, $signed({32'h0, lower_frequency_limit}),
                     $signed({32'h0, upper_frequency_limit})));
    end else begin
      freq_d = 16'(lim_s(reg_q, $signed({32'h0, lower_frequency_limit}),
                     $signed({32'h0, upper_frequency_limit})));
    end
    sat_d = regulator_active && (freq_d >= upper_frequency_limit
                                 || freq_d <= lower_frequency_limit);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_prev_q <= '0;
      integ_q    <= '0;
      reg_q      <= '0;
      in_band_q  <= 1'b0;
      freq_q     <= 16'h0000;
      sat_q      <= 1'b0;
    end else begin
      err_prev_q <= err_prev_d;
      integ_q    <= integ_d;
      reg_q      <= reg_d;
      in_band_q  <= in_band_d;
      freq_q     <= freq_d;
      sat_q      <= sat_d;
    end
  end

endmodule : dpl_loop_top

//--- verif/dpl_loop_checker.sv
// Port-level assertions for the process loop regulator
`timescale 1ns/1ns
module dpl_loop_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] ordinary_frequency_setting,
  input wire logic [15:0] upper_frequency_limit,
  input wire logic [15:0] lower_frequency_limit,
  input wire logic [15:0] frequency_command,
  input wire logic        regulator_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic       ctrl_wr;
  logic [1:0] age_q;
  logic [1:0] age_d;
  assign take    = hsel && htrans[1] && hready;
  assign ctrl_wr = take && hwrite && (haddr[7:0] == 8'h00);
  // Edges since reset release, saturating, so the first loads are skipped
  always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) age_q <= 2'h0;
    else age_q <= age_d;
  end
  // ****************************************
  // Bus and regulator relations
  // ****************************************
  chk_resp_okay:
    assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_read_wait:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  chk_write_nowait:
    assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  chk_rdata_hold:
    assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("hrdata moved");
  chk_mode_on:
    assert property (ctrl_wr ##1 (hwdata[2:0] inside {[3'h1:3'h4]}) |=> regulator_active)
      else $error("mode did not start loop");
  chk_mode_off:
    assert property (ctrl_wr ##1 !(hwdata[2:0] inside {[3'h1:3'h4]}) |=> !regulator_active)
      else $error("mode did not stop loop");
  chk_cmd_follow:
    assert property (age_q == 2'h3 && !regulator_active && !$past(regulator_active)
      |-> frequency_command == $past(ordinary_frequency_setting))
      else $error("command not ordinary setting");
  chk_cmd_limits:
    assert property (regulator_active && $past(regulator_active) && $past(regulator_active, 2)
      |-> frequency_command >= lower_frequency_limit && frequency_command <= upper_frequency_limit)
      else $error("command outside limits");
  cover property (take && !hwrite);
  cover property ($rose(regulator_active));
  cover property ($fell(regulator_active));
endmodule : dpl_loop_checker

bind dpl_loop_top dpl_loop_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .hrdata, .ordinary_frequency_setting, .upper_frequency_limit, .lower_frequency_limit,
  .frequency_command, .regulator_active);

//--- verif/dpl_sensor_model.sv
// Analog inputs and encoder, refreshed every few cycles
`timescale 1ns/1ns
module dpl_sensor_model #(
  parameter int LAG = 1
) (
  input  wire logic [15:0] cur_tgt,
  input  wire logic [15:0] v1_tgt,
  input  wire logic [15:0] v2_tgt,
  input  wire logic [15:0] v3_tgt,
  input  wire logic [15:0] enc_tgt,
  input  wire logic        hclk,
  output logic      [15:0] current_input = 16'h0000,
  output logic      [15:0] voltage_input_one = 16'h0000,
  output logic      [15:0] voltage_input_two = 16'h0000,
  output logic      [15:0] voltage_input_three = 16'h0000,
  output logic      [15:0] encoder_speed = 16'h0000
);
  int cnt = 0;
  always @(posedge hclk) begin
    cnt <= (cnt >= LAG) ? 0 : cnt + 1;
    if (cnt == LAG) begin
      current_input       <= cur_tgt;
      voltage_input_one   <= v1_tgt;
      voltage_input_two   <= v2_tgt;
      voltage_input_three <= v3_tgt;
      encoder_speed       <= enc_tgt;
    end
  end
endmodule : dpl_sensor_model

//--- verif/testbench.sv
// Self-checking bench for the process loop regulator
`timescale 1ns/1ns
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hreadyout, hresp, regulator_active;
  logic [31:0] hrdata;
  logic [15:0] current_input, voltage_input_one, voltage_input_two, voltage_input_three;
  logic [15:0] encoder_speed, frequency_command;
  logic [15:0] main_frequency_setting = 16'h03e8;
  logic [15:0] ordinary_frequency_setting = 16'h0000;
  logic [15:0] upper_frequency_limit = 16'h1388;
  logic [15:0] lower_frequency_limit = 16'h0064;
  logic [15:0] enc_tgt = 16'h1194;
  logic [15:0] ain [4] = '{16'h0064, 16'h00c8, 16'h012c, 16'h0226};
  int          mismatches = 0;
  int          n_compared = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  dpl_loop_top #(.TICK_CYCLES(4)) dut (.*);
  dpl_sensor_model #(.LAG(3)) u_sensors (.hclk(hclk), .cur_tgt(ain[0]), .v1_tgt(ain[1]),
    .v2_tgt(ain[2]), .v3_tgt(ain[3]), .enc_tgt(enc_tgt), .current_input(current_input),
    .voltage_input_one(voltage_input_one), .voltage_input_two(voltage_input_two),
    .voltage_input_three(voltage_input_three), .encoder_speed(encoder_speed));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp(nm, e, r);
  endtask : rd
  task automatic cmd(input logic [15:0] e, input string nm);
    repeat (24) @(posedge hclk);
    cmp(nm, {16'h0, e}, {16'h0, frequency_command});
  endtask : cmd
  function automatic logic [15:0] lim(input int v);
    return (v < 100) ? 16'h0064 : (v > 5000) ? 16'h1388 : 16'(v);
  endfunction : lim
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(8'h0c, 32'h05dc, "gain reset");
    rd(8'h18, 32'h0032, "period reset");
    rd(8'h10, 32'h0000, "integral reset");
    rd(8'h14, 32'h0000, "derivative reset");
    rd(8'h1c, 32'h0014, "band reset");
    rd(8'h20, 32'h0064, "trim limit reset");
    rd(8'h00, 32'h0000, "control reset");
    rd(8'h40, 32'h0000, "unmapped");
    wr(8'h04, 32'h07d0);
    rd(8'h04, 32'h03e8, "voltage set clamp");
    wr(8'h08, 32'h7530);
    rd(8'h08, 32'h5dc0, "speed set clamp");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_sel;
    ordinary_frequency_setting <= 16'h0123;
    cmd(16'h0123, "ordinary");
    wr(8'h0c, 32'h03e8);
    wr(8'h18, 32'h0001);
    wr(8'h1c, 32'h0000);
    wr(8'h04, 32'h01f4);
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 32'h2 | 32'(c << 4));
      cmd(lim(500 - (c[0] ? 1000 - ain[c / 2] : ain[c / 2])), "feedback code");
    end
    for (int r = 0; r < 4; r++) begin
      wr(8'h00, 32'h2051 | 32'(r << 8));
      cmd(lim(700 - ain[r]), "reference code");
    end
    $display("t_sel done");
  endtask : t_sel
  task automatic t_band_ff;
    wr(8'h00, 32'h0022);
    cmd(16'h012c, "proportional");
    wr(8'h1c, 32'h00c8);
    wr(8'h04, 32'h00fa);
    cmd(16'h012c, "band hold");
    wr(8'h1c, 32'h0000);
    cmd(16'h0064, "band off");
    wr(8'h04, 32'h01f4);
    wr(8'h00, 32'h4022);
    cmd(16'h044c, "trim limit");
    wr(8'h20, 32'h01f4);
    cmd(16'h0514, "trim");
    $display("t_band_ff done");
  endtask : t_band_ff
  task automatic t_enc;
    wr(8'h00, 32'h0103);
    cmd(16'h012c, "analog ref encoder");
    wr(8'h08, 32'h1388);
    wr(8'h00, 32'h0004);
    cmd(16'h01f4, "speed set encoder");
    for (int m = 5; m < 8; m++) begin
      wr(8'h00, 32'(m));
      cmd(16'h0123, "spare mode");
    end
    wr(8'h0c, 32'h2710);
    wr(8'h00, 32'h0022);
    cmd(16'h0bb8, "gain max");
    wr(8'h10, 32'h0001);
    cmd(16'h1388, "integral");
    rd(8'h24, 32'h5, "status");
    rd(8'h28, 32'h1388, "freq");
    $display("t_enc done");
  endtask : t_enc
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_sel();
    t_band_ff();
    t_enc();
    wrap_up();
  end
endmodule : testbench
